// [hit_latch_pkg.sv]
// Shared constants for the hit latch and dead-time logic
package hit_latch_pkg;
  localparam int unsigned clk_period_ns = 20;
  localparam int unsigned pulse_spacing_ns = 32;
  localparam int unsigned dead_min_ns = 32;
  localparam int unsigned dead_max_ns = 64;
  localparam int unsigned tap_count = 12;
  localparam int unsigned channel_count = 2;
  localparam logic latch_reset_value = 1'b0;
  localparam logic busy_reset_value = 1'b0;
  localparam logic back_option_default = 1'b0;
  typedef enum logic [1:0] {live, armed, held} chan_state_e;
endpackage

// [time_shift_capture.sv]
// Twin-phase time shift registers and their holding registers
`timescale 1ns/10ps
`default_nettype none
module time_shift_capture
  import hit_latch_pkg::*;
#(
  parameter int unsigned taps = tap_count
) (
  input wire logic clk_in, // System clock
  input wire logic sys_rst_in, // Synchronous reset, high
  input wire logic shift_odd_in, // Gated train, true phase
  input wire logic shift_even_in, // Gated train, inverted phase
  input wire logic latch_in, // Hit latch output
  input wire logic end_of_pulse_strobe_in, // Copy to holding regs
  output logic [taps-1:0] odd_hold_out, // Held odd pattern
  output logic [taps-1:0] even_hold_out // Held even pattern
);
  logic [taps-1:0] odd_shift;
  logic [taps-1:0] even_shift;

  // Shift registers advance on gated train ticks; earlier latch gives more ones
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || end_of_pulse_strobe_in) begin
      odd_shift <= '0;
    end else if (shift_odd_in) begin
      odd_shift <= {odd_shift[taps-2:0], latch_in};
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in || end_of_pulse_strobe_in) begin
      even_shift <= '0;
    end else if (shift_even_in) begin
      even_shift <= {even_shift[taps-2:0], latch_in};
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      odd_hold_out <= '0;
      even_hold_out <= '0;
    end else if (end_of_pulse_strobe_in) begin
      odd_hold_out <= odd_shift;
      even_hold_out <= even_shift;
    end
  end
endmodule // time_shift_capture
`default_nettype wire

// [hit_latch_dead_time.sv]
// Hit latch with next-pulse dead-time extension for one channel
`timescale 1ns/10ps
`default_nettype none
module hit_latch_dead_time
  import hit_latch_pkg::*;
#(
  parameter int unsigned taps = tap_count
) (
  input wire logic clk_in, // System clock, 50 MHz
  input wire logic sys_rst_in, // Synchronous reset, high
  input wire logic front_hit_in, // Front scintillator signal
  input wire logic back_hit_in, // Back scintillator signal
  input wire logic coincidence_enable_in, // Low: back not required
  input wire logic back_single_busy_option_in, // Back alone sets busy
  input wire logic next_pulse_busy_enable_in, // Dead-time extension on
  input wire logic shift_odd_in, // Gated train tick, true phase
  input wire logic shift_even_in, // Gated train tick, inverted phase
  input wire logic end_of_pulse_strobe_in, // End of beam pulse
  output logic hit_latch_out, // Latch state
  output logic next_pulse_busy_out, // Busy for current pulse
  output logic latch_reset_out, // Latch reset held
  output logic [taps-1:0] odd_hold_out, // Held odd time bits
  output logic [taps-1:0] even_hold_out // Held even time bits
);
  ////////////////////////////////////////////////////////////////////////
  logic coincidence;
  logic busy_request;
  logic busy_pending;
  logic next_busy_pending;

  // Back input ignored for coincidence when disabled, like tying it high
  assign coincidence = front_hit_in && (back_hit_in || !coincidence_enable_in);
  // Back-only busy off by default: wide early back would kill next front
  assign next_busy_pending = busy_pending || coincidence || front_hit_in
      || (back_single_busy_option_in && back_hit_in);
  assign busy_request = next_busy_pending;
  assign latch_reset_out = next_pulse_busy_out;

  ////////////////////////////////////////////////////////////////////////
  // Latch: first coincidence wins, cleared at the strobe or while latch reset is held
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || end_of_pulse_strobe_in || latch_reset_out) begin
      hit_latch_out <= latch_reset_value;
    end else if (!hit_latch_out && coincidence) begin
      hit_latch_out <= 1'b1;
    end
  end

  // Any front hit, or back single with the option on, in this pulse is remembered, even while held dead
  always_ff @(posedge clk_in) begin
    if (sys_rst_in || end_of_pulse_strobe_in) begin
      busy_pending <= busy_reset_value;
    end else if (busy_request) begin
      busy_pending <= 1'b1;
    end
  end

  // Busy sampled once per pulse; clears itself after a quiet pulse
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      next_pulse_busy_out <= busy_reset_value;
    end else if (end_of_pulse_strobe_in) begin
      next_pulse_busy_out <= next_pulse_busy_enable_in && busy_request;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  time_shift_capture #(.taps(taps)) capture (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .shift_odd_in(shift_odd_in),
    .shift_even_in(shift_even_in),
    .latch_in(hit_latch_out),
    .end_of_pulse_strobe_in(end_of_pulse_strobe_in),
    .odd_hold_out(odd_hold_out),
    .even_hold_out(even_hold_out)
  );

  ////////////////////////////////////////////////////////////////////////
  latch_holds_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    hit_latch_out && !end_of_pulse_strobe_in |=> hit_latch_out)
    else $error("latch dropped before strobe");
  latch_sets_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !hit_latch_out && coincidence && !latch_reset_out && !end_of_pulse_strobe_in
      |=> hit_latch_out)
    else $error("coincidence did not set latch");
  busy_follows_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    hit_latch_out && end_of_pulse_strobe_in && next_pulse_busy_enable_in
      |=> next_pulse_busy_out)
    else $error("busy not set after hit pulse");
  busy_steady_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !end_of_pulse_strobe_in |=> $stable(next_pulse_busy_out))
    else $error("busy changed mid pulse");
  reset_blocks_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    latch_reset_out |=> !hit_latch_out)
    else $error("latch set while reset held");
  // A hit while latch reset is held, outside the strobe cycle, still sets busy pending
  held_hit_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    latch_reset_out && coincidence && !end_of_pulse_strobe_in |=> busy_pending)
    else $error("held hit lost for busy");
  front_busy_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    front_hit_in && !end_of_pulse_strobe_in |=> busy_pending)
    else $error("front single did not set busy");
  back_gate_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    end_of_pulse_strobe_in && !busy_pending && !front_hit_in && !back_single_busy_option_in
      |=> !next_pulse_busy_out)
    else $error("back alone set busy while option off");
  busy_clears_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    end_of_pulse_strobe_in && !busy_request |=> !next_pulse_busy_out)
    else $error("busy did not self clear");
  // A pulse held dead from strobe to strobe can only have shifted in zeros
  hold_copy_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    end_of_pulse_strobe_in && latch_reset_out |=> odd_hold_out == '0 && even_hold_out == '0)
    else $error("held pulse captured ones");

  hit_cover: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    !hit_latch_out ##1 hit_latch_out);
  dead_cover: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    latch_reset_out && coincidence);
  chain_cover: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    next_pulse_busy_out && end_of_pulse_strobe_in ##1 next_pulse_busy_out);

  ////////////////////////////////////////////////////////////////////////
  // Dead-time bookkeeping. The block works in whole beam pulses: one
  // strobe-to-strobe span stands for one pulse, so the dead window after
  // an accepted hit is the rest of that pulse plus one more, extended while held hits arrive.
  // A real pulse is under two system clocks long, which is why
  // the checks below count strobes rather than cycles.
  // Limitation: the enable is only looked at on the strobe, so toggling it
  // mid pulse takes effect from the next pulse on.
  logic after_hit;
  logic chan_dead;
  logic back_single;

  assign chan_dead = hit_latch_out || latch_reset_out;
  assign back_single = back_single_busy_option_in && back_hit_in && !front_hit_in;

  // Set for the pulse that follows an accepted hit with the extension on
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      after_hit <= busy_reset_value;
    end else if (end_of_pulse_strobe_in) begin
      after_hit <= hit_latch_out && next_pulse_busy_enable_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Lower bound of the dead window: the pulse after a hit is fully held
  dead_span_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    after_hit |-> latch_reset_out && !hit_latch_out)
    else $error("channel live in pulse after hit");

  // Upper bound: a quiet held pulse hands the channel back at its strobe
  dead_end_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    after_hit && end_of_pulse_strobe_in && !busy_request |=> !chan_dead)
    else $error("channel still dead after quiet pulse");

  // Only a coincidence may set the latch
  latch_only_coin_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !hit_latch_out && !coincidence |=> !hit_latch_out)
    else $error("latch set without coincidence");

  // Test mode: with the back requirement off the front alone is a hit
  coin_off_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !coincidence_enable_in && front_hit_in && !hit_latch_out && !latch_reset_out
      && !end_of_pulse_strobe_in |=> hit_latch_out)
    else $error("front alone did not set latch in test mode");

  reset_clears_a: assert property (@(posedge clk_in)
    sys_rst_in |=> !hit_latch_out && !next_pulse_busy_out && !busy_pending)
    else $error("state left over after reset");

  strobe_clear_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    end_of_pulse_strobe_in |=> !hit_latch_out)
    else $error("latch survived the strobe");

  busy_gated_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    end_of_pulse_strobe_in && !next_pulse_busy_enable_in |=> !next_pulse_busy_out)
    else $error("busy set with extension off");

  // A hit seen while held keeps the channel dead for one more pulse
  chain_held_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    end_of_pulse_strobe_in && latch_reset_out && busy_pending && next_pulse_busy_enable_in
      |=> latch_reset_out)
    else $error("held hit did not extend dead time");

  back_busy_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    back_single && !end_of_pulse_strobe_in |=> busy_pending)
    else $error("back single with option on did not set busy");

  // Held bits only move at the strobe, so the scalers downstream see
  // one clean level for the whole following pulse
  for (genvar bit_idx = 0; bit_idx < taps; bit_idx++) begin : g_hold_bits
    hold_bit_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
      !end_of_pulse_strobe_in
        |=> $stable(odd_hold_out[bit_idx]) && $stable(even_hold_out[bit_idx]))
      else $error("held bit moved mid pulse");
  end

  single_cover: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    front_hit_in && !coincidence);
  back_cover: cover property (@(posedge clk_in) disable iff (sys_rst_in)
    back_single);
endmodule // hit_latch_dead_time
`default_nettype wire

// [scint_pair_model.sv]
// Front and back scintillator discriminator pair for one channel
`timescale 1ns/10ps
`default_nettype none
module scint_pair_model (
  input wire logic clk_in, // System clock
  output logic front_out, // Front discriminator pulse
  output logic back_out // Back discriminator pulse
);
  initial begin
    front_out = 1'b0;
    back_out = 1'b0;
  end
  // One-cycle pulses; idle low so a released line never looks like a hit
  task automatic fire(input logic f, input logic b);
    @(posedge clk_in);
    front_out <= f;
    back_out <= b;
    @(posedge clk_in);
    front_out <= 1'b0;
    back_out <= 1'b0;
  endtask
endmodule // scint_pair_model
`default_nettype wire

// [tb_hit_latch_dead_time.sv]
// Testbench for the hit latch with next-pulse dead time
`timescale 1ns/10ps
`default_nettype none
module tb_hit_latch_dead_time;
  import hit_latch_pkg::*;
  logic clk_in, sys_rst_in, front, back, coin_en, back_opt, npb_en, odd, eop, latch, busy, lrst;
  logic [tap_count-1:0] odd_h, even_h;
  int err_total, tests_run;
  scint_pair_model u_scint (.clk_in(clk_in), .front_out(front), .back_out(back));
  hit_latch_dead_time u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .front_hit_in(front),
    .back_hit_in(back), .coincidence_enable_in(coin_en), .back_single_busy_option_in(back_opt),
    .next_pulse_busy_enable_in(npb_en), .shift_odd_in(odd), .shift_even_in(odd),
    .end_of_pulse_strobe_in(eop), .hit_latch_out(latch), .next_pulse_busy_out(busy),
    .latch_reset_out(lrst), .odd_hold_out(odd_h), .even_hold_out(even_h));
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hit(input logic f, input logic b);
    u_scint.fire(f, b);
    #1;
  endtask
  // Strobe or train tick, kept apart so a tick never lands on the strobe
  task automatic step(input logic s, input logic o);
    @(posedge clk_in);
    eop <= s;
    odd <= o;
    @(posedge clk_in);
    eop <= 1'b0;
    odd <= 1'b0;
    #1;
  endtask
  task automatic t_accept;
    hit(1'b1, 1'b1);
    chk(12'(latch), 12'h1);
    hit(1'b1, 1'b1);
    chk(12'(latch), 12'h1);
    step(1'b0, 1'b1);
    step(1'b0, 1'b1);
    step(1'b1, 1'b0);
    chk(12'(latch), 12'h0);
    chk(12'(busy), 12'h1);
    chk(12'(lrst), 12'h1);
    chk(odd_h, 12'h003);
    chk(even_h, 12'h003);
    hit(1'b1, 1'b1);
    chk(12'(latch), 12'h0);
    step(1'b0, 1'b1);
    step(1'b1, 1'b0);
    chk(12'(busy), 12'h1);
    chk(odd_h, 12'h000);
    step(1'b1, 1'b0);
    chk(12'(busy), 12'h0);
  endtask
  task automatic t_singles;
    hit(1'b1, 1'b0);
    chk(12'(latch), 12'h0);
    step(1'b1, 1'b0);
    chk(12'(busy), 12'h1);
    step(1'b1, 1'b0);
    chk(12'(busy), 12'h0);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_in);
      back_opt <= i[0];
      hit(1'b0, 1'b1);
      step(1'b1, 1'b0);
      chk(12'(busy), 12'(i[0]));
      step(1'b1, 1'b0);
    end
    @(posedge clk_in);
    back_opt <= 1'b0;
  endtask
  // Test mode without the back requirement, then the extension switched off
  task automatic t_modes;
    @(posedge clk_in);
    coin_en <= 1'b0;
    hit(1'b1, 1'b0);
    chk(12'(latch), 12'h1);
    step(1'b1, 1'b0);
    chk(12'(busy), 12'h1);
    step(1'b1, 1'b0);
    chk(12'(busy), 12'h0);
    @(posedge clk_in);
    coin_en <= 1'b1;
    npb_en <= 1'b0;
    hit(1'b1, 1'b1);
    step(1'b1, 1'b0);
    chk(12'(latch), 12'h0);
    chk(12'(busy), 12'h0);
    @(posedge clk_in);
    npb_en <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    err_total = 0;
    tests_run = 0;
    sys_rst_in = 1'b1;
    coin_en = 1'b1;
    back_opt = 1'b0;
    npb_en = 1'b1;
    odd = 1'b0;
    eop = 1'b0;
    repeat (10) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_accept();
    t_singles();
    t_modes();
    report_and_stop();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #100000;
    err_total++;
    report_and_stop();
  end
endmodule // tb_hit_latch_dead_time
`default_nettype wire
